// ---- logic/port5_media_defines.vh ----
// constants for the port 5 media interface (nibble mii and serial modes)
// assumes inclusion by bare name from the design file; definitions only
`ifndef PORT5_MEDIA_DEFINES_VH
`define PORT5_MEDIA_DEFINES_VH

// ----------------------------------------------------------------------
// clock rates in hz
// ----------------------------------------------------------------------
`define P5_SYS_CLK_HZ      10000000
`define P5_MII100_CLK_HZ   25000000
`define P5_MII10_CLK_HZ    2500000
`define P5_SNI_CLK_HZ      10000000

// half period of a generated interface clock in system cycles,
// rounded down and never below one cycle
`define P5_HALF_CNT(r) \
  (((`P5_SYS_CLK_HZ / (2 * (r))) < 1) ? 1 : (`P5_SYS_CLK_HZ / (2 * (r))))

// ----------------------------------------------------------------------
// framing figures
// ----------------------------------------------------------------------
`define P5_IPG_BITS        96
`define P5_NIBBLE_BITS     4
`define P5_IPG_NIB_CLKS    (`P5_IPG_BITS / `P5_NIBBLE_BITS)
`define P5_IPG_SNI_CLKS    (`P5_IPG_BITS)

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define P5_NIBBLE_RST      4'h0
`define P5_STATE_RST       3'h1

`endif

// ---- logic/port5_media_interface.v ----
// port 5 media interface: nibble mii in phy or mac role, or serial
// network interface; switch core side is a nibble stream.
// assumes mode straps and link pins come from outside the clk_i domain;
// core side signals are synchronous to clk_i.
`timescale 1ns/1ps
`include "port5_media_defines.vh"

// Overview of operation
// R1: In phy mode the tx valid, tx error and tx nibble pins are inputs and both clocks, collision, carrier, rx valid and rx nibble are driven.
// R2: In mac mode the rx valid and rx nibble outputs feed the partner transmit side and the tx pins take the partner receive side.
// R3: In mac mode the partner supplies both clocks, collision and carrier, the rx clock pin carrying its transmit clock and the tx clock pin its receive clock.
// R4: The interface clock runs at 25 MHz for 100 Mb/s links and at 2.5 MHz for 10 Mb/s links; with the 10 MHz system clock the code gives 5 MHz at 100 Mb/s.
// R5: Nibble modes move four unencoded bits per clock, a quarter of the bit rate.
// R6: No receive error is driven in phy mode and the tx error pin is ignored in mac mode.
// R7: A partner mac with a receive error input ties it low.
// R8: A partner phy with a transmit error input ties it low.
// R9: In half duplex a collision is signalled to the mac side when it occurs during transmission.
// R10: Serial mode uses tx valid, tx nibble bit 0 and tx clock for transmit, and collision, carrier on rx valid, rx nibble bit 0 and rx clock for receive.
// R11: Serial mode moves one unencoded bit per clock at the bit rate; the code gives a 5 MHz serial clock, half of P5_SNI_CLK_HZ.
// R12: Serial mode flags valid data with the enables and reports collisions on the collision pin.
// R13: At least 96 bit times pass between the starts of consecutive transmitted frames.
// R14: Pins change relative to the clock of their direction so the receiver samples on that clock.
module port5_media_interface (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // mode straps
  input  wire       mode_mac_i,
  input  wire       mode_sni_i,
  input  wire       speed_100_i,
  // link pins, partner to device
  input  wire       port5_tx_valid_pin_i,
  input  wire       port5_tx_error_pin_i,
  input  wire [3:0] port5_tx_nibble_i,
  // link pins, device to partner
  output reg        port5_rx_valid_pin_o,
  output reg  [3:0] port5_rx_nibble_o,
  // two-way clock pins
  input  wire       port5_tx_clock_pin_i,
  output reg        port5_tx_clock_pin_o,
  output reg        port5_tx_clock_pin_oe_o,
  input  wire       port5_rx_clock_pin_i,
  output reg        port5_rx_clock_pin_o,
  output reg        port5_rx_clock_pin_oe_o,
  // two-way collision and carrier pins
  input  wire       port5_collision_pin_i,
  output reg        port5_collision_pin_o,
  output reg        port5_collision_pin_oe_o,
  input  wire       port5_carrier_pin_i,
  output reg        port5_carrier_pin_o,
  output reg        port5_carrier_pin_oe_o,
  // core stream toward the partner
  input  wire [3:0] core_tx_data_i,
  input  wire       core_tx_valid_i,
  output reg        core_tx_ready_o,
  // core stream from the partner
  output reg  [3:0] core_rx_data_o,
  output reg        core_rx_valid_o,
  output reg        core_rx_error_o,
  output reg        core_rx_frame_o,
  // collision and carrier, core side
  input  wire       core_col_i,
  input  wire       core_crs_i,
  output reg        core_col_o,
  output reg        core_crs_o
);

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam integer HALF_100_N = `P5_HALF_CNT(`P5_MII100_CLK_HZ);
  localparam integer HALF_10_N  = `P5_HALF_CNT(`P5_MII10_CLK_HZ);
  localparam integer HALF_SNI_N = `P5_HALF_CNT(`P5_SNI_CLK_HZ);
  localparam integer GAP_NIB_N  = `P5_IPG_NIB_CLKS;
  localparam integer GAP_SNI_N  = `P5_IPG_SNI_CLKS;
  localparam [7:0]   HALF_100   = HALF_100_N[7:0];
  localparam [7:0]   HALF_10    = HALF_10_N[7:0];
  localparam [7:0]   HALF_SNI   = HALF_SNI_N[7:0];
  localparam [7:0]   GAP_NIB    = GAP_NIB_N[7:0];
  localparam [7:0]   GAP_SNI    = GAP_SNI_N[7:0];
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_SEND  = 3'h2;
  localparam [2:0] ST_GAP   = 3'h4;

  // half period for the current mode and speed
  function [7:0] half_cnt;
    input serial_network_interface;
    input fast;
    begin
      if (serial_network_interface)
        half_cnt = HALF_SNI;
      else if (fast)
        half_cnt = HALF_100;
      else
        half_cnt = HALF_10;
    end
  endfunction

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  reg  [12:0] meta_q;
  reg  [12:0] sync_q;
  reg         tclk_prev_q;
  reg         rclk_prev_q;
  reg  [1:0]  settle_q;
  // straps valid in sync_q; no pin driven before the role is known
  wire        straps_ok = settle_q[1];
  wire        mac_s  = sync_q[12];
  wire        sni_s  = sync_q[11];
  wire        fast_s = sync_q[10];
  wire        txv_s  = sync_q[9];
  wire        txer_s = sync_q[8];
  wire [3:0]  txd_s  = sync_q[7:4];
  wire        tclk_s = sync_q[3];
  wire        rclk_s = sync_q[2];
  wire        col_s  = sync_q[1];
  wire        crs_s  = sync_q[0];

  // two flops on every pin input
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q      <= 13'h0000;
      sync_q      <= 13'h0000;
      tclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
      settle_q    <= 2'h0;
    end else begin
      settle_q    <= {settle_q[0], 1'b1};
      meta_q      <= {mode_mac_i, mode_sni_i, speed_100_i,
                      port5_tx_valid_pin_i, port5_tx_error_pin_i,
                      port5_tx_nibble_i, port5_tx_clock_pin_i,
                      port5_rx_clock_pin_i, port5_collision_pin_i,
                      port5_carrier_pin_i};
      sync_q      <= meta_q;
      tclk_prev_q <= tclk_s;
      rclk_prev_q <= rclk_s;
    end
  end

  // ----------------------------------------------------------------------
  // interface clock generation, phy and serial roles
  // ----------------------------------------------------------------------
  reg  [7:0] div_q;
  reg        gen_q;
  wire       div_end = (div_q + 8'h01) >= half_cnt(sni_s, fast_s); // R4 R11
  wire       gen_rise = div_end & ~gen_q;
  wire       gen_fall = div_end & gen_q;

  // divider toggles the clock every half period
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= 8'h00;
      gen_q <= 1'b0;
    end else if (div_end) begin
      div_q <= 8'h00;
      gen_q <= ~gen_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // sample and drive strobes per role
  wire sample_edge = mac_s ? (tclk_prev_q & ~tclk_s) : gen_rise; // R14 R3
  wire drive_edge  = mac_s ? (rclk_s & ~rclk_prev_q) : gen_fall; // R14 R3

  // ----------------------------------------------------------------------
  // outbound path: core stream to rx pins
  // ----------------------------------------------------------------------
  reg  [2:0] state_q, state_d;
  reg  [3:0] hold_q;
  reg        hold_full_q, hold_full_d;
  reg  [3:0] shift_q, shift_d;
  reg  [1:0] bitcnt_q, bitcnt_d;
  reg  [7:0] gap_q, gap_d;
  reg  [3:0] nib_q, nib_d;
  reg        val_q, val_d;
  wire       accept = core_tx_valid_i & core_tx_ready_o & ~hold_full_q;
  wire       need_new = ~sni_s | (bitcnt_q == 2'h3);

  // framing state machine, advanced on the drive strobe
  always @* begin
    state_d     = state_q;
    shift_d     = shift_q;
    bitcnt_d    = bitcnt_q;
    gap_d       = gap_q;
    nib_d       = nib_q;
    val_d       = val_q;
    hold_full_d = hold_full_q | accept;
    if (drive_edge) begin
      case (state_q)
        ST_IDLE: begin
          if (hold_full_q) begin
            shift_d     = hold_q;
            bitcnt_d    = 2'h0;
            hold_full_d = 1'b0;
            val_d       = 1'b1; // R12
            nib_d       = sni_s ? {3'h0, hold_q[0]} : hold_q; // R5 R10
            state_d     = ST_SEND;
          end
        end
        ST_SEND: begin
          if (need_new && hold_full_q) begin
            shift_d     = hold_q;
            bitcnt_d    = 2'h0;
            hold_full_d = 1'b0;
            nib_d       = sni_s ? {3'h0, hold_q[0]} : hold_q; // R2 R5
          end else if (need_new) begin
            val_d    = 1'b0;
            nib_d    = `P5_NIBBLE_RST;
            gap_d    = (sni_s ? GAP_SNI : GAP_NIB) - 8'h01; // R13
            state_d  = ST_GAP;
          end else begin
            shift_d  = {1'b0, shift_q[3:1]};
            bitcnt_d = bitcnt_q + 2'h1;
            nib_d    = {3'h0, shift_q[1]}; // R11
          end
        end
        ST_GAP: begin
          if (gap_q == 8'h00)
            state_d = ST_IDLE; // R13
          else
            gap_d = gap_q - 8'h01;
        end
        default: begin
          state_d = ST_IDLE;
          val_d   = 1'b0;
        end
      endcase
    end
  end

  // outbound registers
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q         <= `P5_STATE_RST;
      hold_q          <= `P5_NIBBLE_RST;
      hold_full_q     <= 1'b0;
      shift_q         <= `P5_NIBBLE_RST;
      bitcnt_q        <= 2'h0;
      gap_q           <= 8'h00;
      nib_q           <= `P5_NIBBLE_RST;
      val_q           <= 1'b0;
      core_tx_ready_o <= 1'b0;
    end else begin
      state_q         <= state_d;
      if (accept)
        hold_q <= core_tx_data_i;
      hold_full_q     <= hold_full_d;
      shift_q         <= shift_d;
      bitcnt_q        <= bitcnt_d;
      gap_q           <= gap_d;
      nib_q           <= nib_d;
      val_q           <= val_d;
      core_tx_ready_o <= ~hold_full_d;
    end
  end

  // ----------------------------------------------------------------------
  // inbound path: tx pins to core stream
  // ----------------------------------------------------------------------
  reg [3:0] in_sh_q;
  reg [1:0] in_cnt_q;

  // capture nibbles or serial bits on the sample strobe
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      in_sh_q         <= `P5_NIBBLE_RST;
      in_cnt_q        <= 2'h0;
      core_rx_data_o  <= `P5_NIBBLE_RST;
      core_rx_valid_o <= 1'b0;
      core_rx_error_o <= 1'b0;
      core_rx_frame_o <= 1'b0;
    end else begin
      core_rx_valid_o <= 1'b0;
      core_rx_error_o <= 1'b0;
      if (sample_edge) begin
        core_rx_frame_o <= txv_s; // R12
        if (!txv_s) begin
          in_cnt_q <= 2'h0;
        end else if (sni_s) begin
          in_sh_q  <= {txd_s[0], in_sh_q[3:1]}; // R10 R11
          in_cnt_q <= in_cnt_q + 2'h1;
          if (in_cnt_q == 2'h3) begin
            core_rx_data_o  <= {txd_s[0], in_sh_q[3:1]};
            core_rx_valid_o <= 1'b1;
          end
        end else begin
          core_rx_data_o  <= txd_s; // R1 R2 R5
          core_rx_valid_o <= 1'b1;
          core_rx_error_o <= txer_s & ~mac_s; // R6
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers, collision and carrier
  // ----------------------------------------------------------------------
  // clocks and collision are driven in phy and serial roles only, carrier in phy role only
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      port5_rx_valid_pin_o     <= 1'b0;
      port5_rx_nibble_o        <= `P5_NIBBLE_RST;
      port5_tx_clock_pin_o     <= 1'b0;
      port5_tx_clock_pin_oe_o  <= 1'b0;
      port5_rx_clock_pin_o     <= 1'b0;
      port5_rx_clock_pin_oe_o  <= 1'b0;
      port5_collision_pin_o    <= 1'b0;
      port5_collision_pin_oe_o <= 1'b0;
      port5_carrier_pin_o      <= 1'b0;
      port5_carrier_pin_oe_o   <= 1'b0;
      core_col_o               <= 1'b0;
      core_crs_o               <= 1'b0;
    end else begin
      port5_rx_valid_pin_o     <= val_d | (sni_s & core_crs_i); // R10
      port5_rx_nibble_o        <= nib_d;
      port5_tx_clock_pin_o     <= div_end ? ~gen_q : gen_q; // R1 R4
      port5_rx_clock_pin_o     <= div_end ? ~gen_q : gen_q; // R1
      port5_tx_clock_pin_oe_o  <= ~mac_s & straps_ok; // R3
      port5_rx_clock_pin_oe_o  <= ~mac_s & straps_ok; // R3
      port5_collision_pin_o    <= core_col_i & ~mac_s; // R9 R12
      port5_collision_pin_oe_o <= ~mac_s & straps_ok; // R1 R3
      port5_carrier_pin_o      <= core_crs_i & ~mac_s & ~sni_s; // R1
      port5_carrier_pin_oe_o   <= ~mac_s & ~sni_s & straps_ok; // R3 R10
      core_col_o               <= mac_s & col_s; // R3 R9
      core_crs_o               <= mac_s & crs_s; // R3
    end
  end

endmodule

// ---- bench/port5_media_asserts.sv ----
// checker for the port 5 media interface ports
// assumes the bind below; straps steady for several cycles
`timescale 1ns/1ps
module port5_media_asserts (
  // clock, reset, straps
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       mode_mac_i,
  input wire       mode_sni_i,
  input wire       speed_100_i,
  // pins and core side
  input wire       port5_rx_valid_pin_o,
  input wire [3:0] port5_rx_nibble_o,
  input wire       port5_tx_clock_pin_o,
  input wire       port5_tx_clock_pin_oe_o,
  input wire       port5_rx_clock_pin_o,
  input wire       port5_rx_clock_pin_oe_o,
  input wire       port5_collision_pin_o,
  input wire       port5_collision_pin_oe_o,
  input wire       port5_carrier_pin_oe_o,
  input wire       core_rx_valid_o,
  input wire       core_rx_error_o,
  input wire       core_col_i
);
  reg [7:0] gap_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ---
  // idle cycles on the rx valid pin
  // ---
  always @(posedge clk_i) begin
    if (!rst_n_i)
      gap_q <= 8'hFF;
    else if (port5_rx_valid_pin_o)
      gap_q <= 8'h00;
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  end
  // ---
  // properties
  // ---
  a_mac_pins_free: assert property (mode_mac_i[*6] |->
    !(port5_tx_clock_pin_oe_o | port5_rx_clock_pin_oe_o |
      port5_collision_pin_oe_o | port5_carrier_pin_oe_o))
    else $error("pin driven in mac role");
  a_phy_pins_drive: assert property ((!mode_mac_i)[*6] |->
    port5_tx_clock_pin_oe_o && port5_rx_clock_pin_oe_o &&
    port5_collision_pin_oe_o) else $error("clock pin not driven");
  a_slow_clk_rate: assert property (
    (!mode_mac_i && !mode_sni_i && !speed_100_i)[*6]
    ##0 $changed(port5_tx_clock_pin_o) |=> $stable(port5_tx_clock_pin_o)
    ##1 $changed(port5_tx_clock_pin_o)) else $error("slow clock rate");
  a_bits_zero: assert property ((mode_sni_i && !mode_mac_i)[*8]
    |-> port5_rx_nibble_o[3:1] == 3'h0) else $error("upper bits set");
  a_col_follow: assert property ((!mode_mac_i)[*6] ##0
    $rose(core_col_i) |=> port5_collision_pin_o)
    else $error("collision not shown");
  a_err_nibble_only: assert property ((mode_mac_i || mode_sni_i)[*6]
    |-> !core_rx_error_o) else $error("receive error outside phy");
  a_rx_pulse: assert property (core_rx_valid_o |=> !core_rx_valid_o)
    else $error("rx valid too long");
  a_frame_gap: assert property (!mode_mac_i && !mode_sni_i &&
    $rose(port5_rx_valid_pin_o) |-> gap_q >= 8'd45)
    else $error("frame gap too short");
  a_quiet_after_reset: assert property ($rose(rst_n_i) |=>
    (!(port5_tx_clock_pin_oe_o | port5_rx_clock_pin_oe_o |
       port5_collision_pin_oe_o | port5_carrier_pin_oe_o))[*2])
    else $error("pin driven before role known");
  a_rx_clk_same: assert property ((!mode_mac_i)[*6] |->
    port5_rx_clock_pin_o == port5_tx_clock_pin_o)
    else $error("rx clock differs from tx clock");
  c_phy_frame: cover property (!mode_mac_i && $rose(port5_rx_valid_pin_o));
  c_mac_rx: cover property (mode_mac_i && core_rx_valid_o);
  c_serial_rx: cover property (mode_sni_i && core_rx_valid_o);
endmodule

bind port5_media_interface port5_media_asserts u_chk (.clk_i, .rst_n_i,
  .mode_mac_i, .mode_sni_i, .speed_100_i, .port5_rx_valid_pin_o,
  .port5_rx_nibble_o, .port5_tx_clock_pin_o, .port5_tx_clock_pin_oe_o,
  .port5_rx_clock_pin_o, .port5_rx_clock_pin_oe_o, .port5_collision_pin_o,
  .port5_collision_pin_oe_o, .port5_carrier_pin_oe_o, .core_rx_valid_o,
  .core_rx_error_o, .core_col_i);

// ---- bench/port5_partner_model.sv ----
// far side model: a mac in the phy role, a phy in the mac role
// assumes link_clk is the resolved tx clock pin level
`timescale 1ns/1ps
module port5_partner_model (
  // role and clocks
  input  wire       mac_role,
  input  wire       link_clk,
  output reg        phy_clk,
  // device pins seen here
  input  wire       dev_valid,
  input  wire [3:0] dev_nibble,
  // pins into the device
  output reg        part_valid,
  output reg        part_err,
  output reg  [3:0] part_nibble
);
  logic [3:0] send_q[$];
  logic [3:0] got_q[$];
  logic       err_en = 1'b0;
  // ---
  // 800 ns phy clock, mac role only
  // ---
  initial begin
    phy_clk = 1'b0;
    part_valid = 1'b0;
    part_err = 1'b0;
    part_nibble = 4'h0;
    #37;
    forever #400 phy_clk = mac_role & ~phy_clk;
  end
  // next unit; when idle, valid and error go low and the nibble pins show the inverse of the last value
  task automatic drive;
    begin
      if (send_q.size() != 0) begin
        part_valid <= 1'b1;
        part_err <= err_en;
        part_nibble <= send_q.pop_front();
      end else begin
        part_valid <= 1'b0;
        part_err <= 1'b0;
        part_nibble <= ~part_nibble;
      end
    end
  endtask
  // take on rising, drive on the edge the device does not sample
  always @(posedge link_clk) begin
    if (dev_valid === 1'b1)
      got_q.push_back(dev_nibble);
    if (mac_role)
      drive;
  end
  always @(negedge link_clk)
    if (!mac_role)
      drive;
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the port 5 media interface
// assumes the partner model and checker are compiled first
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h seen %0h", n, e, s); end end
module tb_top;
  // ---
  // stimulus and pins
  // ---
  reg        clk_i = 1'b0, rst_n_i = 1'b0, mode_mac_i = 1'b0;
  reg        mode_sni_i = 1'b0, speed_100_i = 1'b0, core_tx_valid_i = 1'b0;
  reg        core_col_i = 1'b0, core_crs_i = 1'b0, p_col = 1'b0;
  reg        p_crs = 1'b0;
  reg  [3:0] core_tx_data_i = 4'h0;
  wire       port5_tx_valid_pin_i, port5_tx_error_pin_i, phy_clk;
  wire [3:0] port5_tx_nibble_i, port5_rx_nibble_o, core_rx_data_o;
  wire       port5_rx_valid_pin_o, port5_tx_clock_pin_o;
  wire       port5_rx_clock_pin_o, port5_tx_clock_pin_oe_o;
  wire       port5_rx_clock_pin_oe_o, port5_collision_pin_o;
  wire       port5_collision_pin_oe_o, port5_carrier_pin_o;
  wire       port5_carrier_pin_oe_o, core_tx_ready_o, core_rx_valid_o;
  wire       core_rx_error_o, core_col_o, core_crs_o, core_rx_frame_o;
  wire [3:0] oes = {port5_tx_clock_pin_oe_o, port5_rx_clock_pin_oe_o,
                    port5_collision_pin_oe_o, port5_carrier_pin_oe_o};
  logic [3:0] rx_q[$];
  int        errors = 0, checked = 0, cyc = 0, k;
  logic [7:0] errs_seen = 8'h00;
  // pin levels from whichever side drives
  wire port5_tx_clock_pin_i = port5_tx_clock_pin_oe_o ?
                              port5_tx_clock_pin_o : phy_clk;
  wire port5_rx_clock_pin_i = port5_rx_clock_pin_oe_o ?
                              port5_rx_clock_pin_o : phy_clk;
  wire port5_collision_pin_i = port5_collision_pin_oe_o ?
                               port5_collision_pin_o : p_col;
  wire port5_carrier_pin_i = port5_carrier_pin_oe_o ?
                             port5_carrier_pin_o : p_crs;
  port5_media_interface uut (.clk_i, .rst_n_i, .mode_mac_i, .mode_sni_i,
    .speed_100_i, .port5_tx_valid_pin_i, .port5_tx_error_pin_i,
    .port5_tx_nibble_i, .port5_rx_valid_pin_o, .port5_rx_nibble_o,
    .port5_tx_clock_pin_i, .port5_tx_clock_pin_o, .port5_tx_clock_pin_oe_o,
    .port5_rx_clock_pin_i, .port5_rx_clock_pin_o, .port5_rx_clock_pin_oe_o,
    .port5_collision_pin_i, .port5_collision_pin_o,
    .port5_collision_pin_oe_o, .port5_carrier_pin_i, .port5_carrier_pin_o,
    .port5_carrier_pin_oe_o, .core_tx_data_i, .core_tx_valid_i,
    .core_tx_ready_o, .core_rx_data_o, .core_rx_valid_o, .core_rx_error_o,
    .core_rx_frame_o, .core_col_i, .core_crs_i, .core_col_o, .core_crs_o);
  port5_partner_model u_part (.mac_role(mode_mac_i),
    .link_clk(port5_tx_clock_pin_i), .phy_clk,
    .dev_valid(port5_rx_valid_pin_o), .dev_nibble(port5_rx_nibble_o),
    .part_valid(port5_tx_valid_pin_i), .part_err(port5_tx_error_pin_i),
    .part_nibble(port5_tx_nibble_i));
  // clock, timeout, core receive monitor
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict;
    end
    if (core_rx_valid_o === 1'b1) begin
      rx_q.push_back(core_rx_data_o);
      errs_seen += core_rx_error_o;
      `CHK("rx frame", 1'b1, core_rx_frame_o)
    end
  end
  // ---
  // shared tasks
  // ---
  task give_verdict;
    begin
      $display("checked %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task automatic restart(input logic mac, input logic serial_network_interface, input logic f);
    begin
      rst_n_i <= 1'b0;
      mode_mac_i <= mac;
      mode_sni_i <= serial_network_interface;
      speed_100_i <= f;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rx_q.delete();
      u_part.got_q.delete();
      errs_seen = 0;
    end
  endtask
  task automatic send(input logic [3:0] d[$]);
    begin
      foreach (d[i]) begin
        core_tx_data_i <= d[i];
        core_tx_valid_i <= 1'b1;
        k = 0;
        do begin
          @(posedge clk_i);
          k++;
        end while (core_tx_ready_o !== 1'b1 && k < 400);
        `CHK("tx ready", 1'b1, core_tx_ready_o)
      end
      core_tx_valid_i <= 1'b0;
    end
  endtask
  // wait for units at the partner (dev) or core side, then compare
  task automatic got(input bit dev, input logic [3:0] e[$]);
    logic [3:0] q[$];
    begin
      for (k = 0; k < 3000; k++) begin
        if (dev)
          q = u_part.got_q;
        else
          q = rx_q;
        if (q.size() >= e.size())
          break;
        @(posedge clk_i);
      end
      `CHK("count", e.size(), q.size())
      foreach (e[i]) `CHK("nibble", e[i], q[i])
    end
  endtask
  // ---
  // scenarios
  // ---
  task automatic t_phy(input logic f);
    begin
      restart(1'b0, 1'b0, f);
      send('{4'h1, 4'hA, 4'h5, 4'hF});
      got(1'b1, '{4'h1, 4'hA, 4'h5, 4'hF});
      for (k = 0; k < 50 && port5_rx_valid_pin_o; k++) @(posedge clk_i);
      send('{4'h3});
      got(1'b1, '{4'h1, 4'hA, 4'h5, 4'hF, 4'h3});
      u_part.err_en = 1'b1;
      u_part.send_q = '{4'h6, 4'h9, 4'hC};
      got(1'b0, '{4'h6, 4'h9, 4'hC});
      `CHK("rx errors", 3, errs_seen)
      core_col_i <= 1'b1;
      core_crs_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("collision", 1'b1, port5_collision_pin_i)
      `CHK("carrier", 1'b1, port5_carrier_pin_i)
      core_col_i <= 1'b0;
      core_crs_i <= 1'b0;
      u_part.err_en = 1'b0;
      $display("phy role test done");
    end
  endtask
  task automatic t_serial;
    begin
      restart(1'b0, 1'b1, 1'b1);
      send('{4'h6});
      got(1'b1, '{4'h0, 4'h1, 4'h1, 4'h0});
      u_part.err_en = 1'b1;
      u_part.send_q = '{4'h1, 4'h0, 4'h1, 4'h1};
      got(1'b0, '{4'hD});
      `CHK("rx errors", 0, errs_seen)
      core_crs_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("carrier", 1'b1, port5_rx_valid_pin_o)
      `CHK("frame end", 1'b0, core_rx_frame_o)
      core_crs_i <= 1'b0;
      u_part.err_en = 1'b0;
      $display("serial test done");
    end
  endtask
  task automatic t_mac;
    begin
      restart(1'b1, 1'b0, 1'b1);
      `CHK("pins driven", 4'h0, oes)
      send('{4'h2, 4'h7});
      got(1'b1, '{4'h2, 4'h7});
      u_part.err_en = 1'b1;
      u_part.send_q = '{4'hB, 4'h4};
      got(1'b0, '{4'hB, 4'h4});
      `CHK("rx errors", 0, errs_seen)
      p_col <= 1'b1;
      p_crs <= 1'b1;
      repeat (6) @(posedge clk_i);
      `CHK("core collision", 1'b1, core_col_o)
      `CHK("core carrier", 1'b1, core_crs_o)
      p_col <= 1'b0;
      p_crs <= 1'b0;
      u_part.err_en = 1'b0;
      $display("mac role test done");
    end
  endtask
  initial begin
    t_phy(1'b1);
    t_phy(1'b0);
    t_serial;
    t_mac;
    give_verdict;
  end
endmodule
